// *** hdl/cbs_pkg.sv ***
package cbs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FID_LO = 8'h04;
    localparam logic [7:0] OFS_FID_HI = 8'h08;
    localparam logic [7:0] OFS_DLC_LO = 8'h0C;
    localparam logic [7:0] OFS_DLC_HI = 8'h10;
    localparam logic [7:0] OFS_AICB = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CUR_LO = 8'h1C;
    localparam logic [7:0] OFS_CUR_HI = 8'h20;
    // Control register fields and reset value
    localparam int unsigned CTRL_ENH_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Air-initiated event register fields
    localparam int unsigned AICB_START_BIT = 0;
    localparam int unsigned AICB_END_BIT = 1;
    localparam int unsigned AICB_II_LSB = 4;
    // Status register fields
    localparam int unsigned STAT_ACTIVE_BIT = 0;
    localparam int unsigned STAT_NUM_BIT = 1;
    localparam int unsigned STAT_SRC_BIT = 2;
    localparam int unsigned STAT_PFID_BIT = 3;
    localparam int unsigned STAT_PDLC_BIT = 4;
    localparam int unsigned STAT_AICB_BIT = 5;
    localparam int unsigned STAT_OWED_LSB = 16;
    // Message field widths
    localparam int unsigned MB_W = 56;
    localparam int unsigned HI_W = 24;
    localparam int unsigned NUM_II = 16;
    // Downlink request codes
    localparam logic [4:0] DR_NONE = 5'h00;
    localparam logic [4:0] DR_AICB = 5'h01;
    localparam logic [4:0] DR_BCAST1 = 5'h04;
    localparam logic [4:0] DR_BCAST2 = 5'h05;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing: clock rate, tick period and hold time
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned TICK_MS = 1000;
    localparam int unsigned TICK_CYCLES_DEF = int'((CLK_HZ * TICK_MS) / 1000);
    localparam int unsigned HOLD_S = 18;
    localparam logic [4:0] HOLD_TICKS = 5'(HOLD_S * 1000 / TICK_MS);
    // Message sources
    typedef enum logic {SRC_FID, SRC_DLC} cbs_src_t;
endpackage

// *** hdl/cbs_tick.sv ***
`timescale 1ns/1ns
module cbs_tick #(
    parameter int unsigned DIV = 100
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // One-cycle tick
    output logic tick
);
    logic [31:0] cnt_q; // Prescaler count
    logic [31:0] cnt_d;

    // Counts down to zero, then reloads
    always_comb begin
        if (cnt_q == 32'h0000_0000) begin
            cnt_d = 32'(DIV - 1);
        end else begin
            cnt_d = cnt_q - 32'h0000_0001;
        end
    end

    // Register the count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Tick when the count wraps
    assign tick = aresetn && (cnt_q == 32'h0000_0000);
endmodule

// *** hdl/cbs_seq.sv ***
`timescale 1ns/1ns
// Contract
// - Start broadcast only with no air-initiated transaction
// - New message never preempts current broadcast
// - Expiry clears code, drops message, toggles number
// - Air-initiated start stops and clears timer
// - After air-initiated end, fresh hold period
// - Waiting messages start their timer when current
// - Updated waiting message keeps only latest value
// - Only flight ID and capability report broadcast
// - Enhanced mode tracks interruption per identifier
// - Next broadcast only after all timers expire
// - Each new broadcast uses alternate request code
// - Entry starts broadcast; unchanged value ignored
// - Queue in arrival order, each held full period
module cbs_seq
    import cbs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = cbs_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data and response
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Reply encoder side
    input wire logic [3:0] reply_ii,
    output logic [4:0] reply_dr,
    output logic [cbs_pkg::MB_W-1:0] reply_mb,
    output logic bcast_active
);
    import cbs_pkg::*;

    typedef enum logic {ST_IDLE, ST_BCAST} cbs_state_t;

    // Known register offsets
    function automatic logic reg_known(input logic [7:0] a);
        reg_known = (a == OFS_CTRL) || (a == OFS_FID_LO) || (a == OFS_FID_HI) || (a == OFS_DLC_LO) ||
            (a == OFS_DLC_HI) || (a == OFS_AICB) || (a == OFS_STATUS) || (a == OFS_CUR_LO) ||
            (a == OFS_CUR_HI);
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        merge = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                merge[b*8 +: 8] = n[b*8 +: 8];
            end
        end
    endfunction

    // AXI slave state
    logic aw_have_q, aw_have_d, w_have_q, w_have_d; // Held address and data
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire; // Write performed this cycle

    // Software registers and sequencer state
    logic [31:0] ctrl_q, ctrl_d, fid_lo_q, fid_lo_d, dlc_lo_q, dlc_lo_d;
    cbs_state_t state_q, state_d;
    cbs_src_t src_q, src_d; // Source of current message
    logic num_q, num_d; // Message number, 0 means 1
    logic [MB_W-1:0] cur_mb_q, cur_mb_d; // Comm-B buffer
    logic [MB_W-1:0] pfid_mb_q, pfid_mb_d, pdlc_mb_q, pdlc_mb_d; // Waiting messages
    logic [MB_W-1:0] last_fid_q, last_fid_d, last_dlc_q, last_dlc_d; // Last accepted values
    logic pfid_q, pfid_d, pdlc_q, pdlc_d; // Waiting flags
    logic older_dlc_q, older_dlc_d; // Capability report arrived first
    logic [4:0] reply_dr_q, reply_dr_d;
    logic [MB_W-1:0] reply_mb_q, reply_mb_d;

    // Events and per-identifier vectors
    logic fid_wr, dlc_wr, ai_start_ev, ai_end_ev, bcast_start, tick;
    logic [MB_W-1:0] new_mb;
    logic [NUM_II-1:0] ai_start_hit, ai_end_hit, owed, aicb;

    // Handshake outputs
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    // Write side events, decoded from the held address
    assign new_mb = {wdata_q[HI_W-1:0], (awaddr_q == OFS_FID_HI) ? fid_lo_q : dlc_lo_q};
    assign fid_wr = wr_fire && (awaddr_q == OFS_FID_HI);
    assign dlc_wr = wr_fire && (awaddr_q == OFS_DLC_HI);
    assign ai_start_ev = wr_fire && (awaddr_q == OFS_AICB) && wdata_q[AICB_START_BIT];
    assign ai_end_ev = wr_fire && (awaddr_q == OFS_AICB) && wdata_q[AICB_END_BIT];

    // AXI channels and register read mux
    always_comb begin
        aw_have_d = aw_have_q;
        awaddr_d = awaddr_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        fid_lo_d = fid_lo_q;
        dlc_lo_d = dlc_lo_q;
        // Take address and data in either order
        if (s_axi_awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        // Perform the write once both are held
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = reg_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            case (awaddr_q)
                OFS_CTRL: ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
                OFS_FID_LO: fid_lo_d = merge(fid_lo_q, wdata_q, wstrb_q);
                OFS_DLC_LO: dlc_lo_d = merge(dlc_lo_q, wdata_q, wstrb_q);
                default: ctrl_d = ctrl_q;
            endcase
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Read answer one cycle after address
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_d = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_CTRL: rdata_d = ctrl_q;
                OFS_FID_LO: rdata_d = fid_lo_q;
                OFS_DLC_LO: rdata_d = dlc_lo_q;
                OFS_AICB: rdata_d[NUM_II-1:0] = aicb;
                OFS_STATUS: begin
                    rdata_d[STAT_ACTIVE_BIT] = (state_q == ST_BCAST);
                    rdata_d[STAT_NUM_BIT] = num_q;
                    rdata_d[STAT_SRC_BIT] = (src_q == SRC_DLC);
                    rdata_d[STAT_PFID_BIT] = pfid_q;
                    rdata_d[STAT_PDLC_BIT] = pdlc_q;
                    rdata_d[STAT_AICB_BIT] = |aicb;
                    rdata_d[STAT_OWED_LSB +: NUM_II] = owed;
                end
                OFS_CUR_LO: rdata_d = cur_mb_q[31:0];
                OFS_CUR_HI: rdata_d[HI_W-1:0] = cur_mb_q[MB_W-1:32];
                default: rdata_d = 32'h0000_0000;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // AXI and software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            ctrl_q <= CTRL_RESET;
            fid_lo_q <= 32'h0000_0000;
            dlc_lo_q <= 32'h0000_0000;
        end else begin
            aw_have_q <= aw_have_d;
            awaddr_q <= awaddr_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            fid_lo_q <= fid_lo_d;
            dlc_lo_q <= dlc_lo_d;
        end
    end

    // Hold timer timebase
    cbs_tick #(.DIV(TICK_CYCLES)) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    // Start only when idle, something waits and no air-initiated traffic
    assign bcast_start = (state_q == ST_IDLE) && (pfid_q || pdlc_q) && !(|aicb) && !ai_start_ev;

    // Per-identifier interruption and hold timers
    for (genvar i = 0; i < NUM_II; i++) begin : g_ii
        logic aicb_q, aicb_d, owed_q, owed_d;
        logic [4:0] tmr_q, tmr_d;
        // Enhanced mode hits one identifier, otherwise all
        assign ai_start_hit[i] = ai_start_ev
            && (!ctrl_q[CTRL_ENH_BIT] || wdata_q[AICB_II_LSB +: 4] == 4'(i));
        assign ai_end_hit[i] = ai_end_ev && (!ctrl_q[CTRL_ENH_BIT] || wdata_q[AICB_II_LSB +: 4] == 4'(i));
        assign owed[i] = owed_q;
        assign aicb[i] = aicb_q;
        // Timer next state
        always_comb begin
            aicb_d = aicb_q;
            owed_d = owed_q;
            tmr_d = tmr_q;
            if (ai_start_hit[i]) begin
                aicb_d = 1'b1;
            end else if (ai_end_hit[i]) begin
                aicb_d = 1'b0;
            end
            if (bcast_start) begin
                owed_d = 1'b1;
                tmr_d = HOLD_TICKS;
            end else if (owed_q && (ai_start_hit[i] || ai_end_hit[i])) begin
                tmr_d = HOLD_TICKS;
            end else if (owed_q && !aicb_q && tick) begin
                // Count one tick, expire at the last
                if (tmr_q == 5'h01) begin
                    owed_d = 1'b0;
                    tmr_d = 5'h00;
                end else begin
                    tmr_d = tmr_q - 5'h01;
                end
            end
        end
        // Timer registers
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                aicb_q <= 1'b0;
                owed_q <= 1'b0;
                tmr_q <= 5'h00;
            end else begin
                aicb_q <= aicb_d;
                owed_q <= owed_d;
                tmr_q <= tmr_d;
            end
        end
    end

    // Queue, current message and reply codes
    always_comb begin
        state_d = state_q;
        src_d = src_q;
        num_d = num_q;
        cur_mb_d = cur_mb_q;
        pfid_d = pfid_q;
        pdlc_d = pdlc_q;
        pfid_mb_d = pfid_mb_q;
        pdlc_mb_d = pdlc_mb_q;
        last_fid_d = last_fid_q;
        last_dlc_d = last_dlc_q;
        older_dlc_d = older_dlc_q;
        case (state_q)
            ST_IDLE: begin
                // Load oldest waiting message into the buffer
                if (bcast_start) begin
                    state_d = ST_BCAST;
                    if (pdlc_q && (!pfid_q || older_dlc_q)) begin
                        src_d = SRC_DLC;
                        cur_mb_d = pdlc_mb_q;
                        pdlc_d = 1'b0;
                    end else begin
                        src_d = SRC_FID;
                        cur_mb_d = pfid_mb_q;
                        pfid_d = 1'b0;
                    end
                end
            end
            ST_BCAST: begin
                // Ends only when every identifier has timed out
                if (owed == '0) begin
                    state_d = ST_IDLE;
                    cur_mb_d = '0;
                    num_d = !num_q;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // New entries only touch the waiting slots
        if (fid_wr && new_mb != last_fid_q) begin
            last_fid_d = new_mb;
            pfid_mb_d = new_mb;
            if (!pfid_d) begin
                older_dlc_d = pdlc_d;
            end
            pfid_d = 1'b1;
        end
        if (dlc_wr && new_mb != last_dlc_q) begin
            last_dlc_d = new_mb;
            pdlc_mb_d = new_mb;
            if (!pdlc_d) begin
                older_dlc_d = !pfid_d;
            end
            pdlc_d = 1'b1;
        end
        // Reply fields for the identifier being answered
        reply_mb_d = '0;
        if (aicb[reply_ii]) begin
            reply_dr_d = DR_AICB;
        end else if ((state_q == ST_BCAST) && owed[reply_ii]) begin
            reply_dr_d = num_q ? DR_BCAST2 : DR_BCAST1;
            reply_mb_d = cur_mb_q;
        end else begin
            reply_dr_d = DR_NONE;
        end
    end

    // Sequencer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            src_q <= SRC_FID;
            num_q <= 1'b0;
            cur_mb_q <= '0;
            pfid_q <= 1'b0;
            pdlc_q <= 1'b0;
            pfid_mb_q <= '0;
            pdlc_mb_q <= '0;
            last_fid_q <= '0;
            last_dlc_q <= '0;
            older_dlc_q <= 1'b0;
            reply_dr_q <= DR_NONE;
            reply_mb_q <= '0;
        end else begin
            state_q <= state_d;
            src_q <= src_d;
            num_q <= num_d;
            cur_mb_q <= cur_mb_d;
            pfid_q <= pfid_d;
            pdlc_q <= pdlc_d;
            pfid_mb_q <= pfid_mb_d;
            pdlc_mb_q <= pdlc_mb_d;
            last_fid_q <= last_fid_d;
            last_dlc_q <= last_dlc_d;
            older_dlc_q <= older_dlc_d;
            reply_dr_q <= reply_dr_d;
            reply_mb_q <= reply_mb_d;
        end
    end

    // Reply outputs
    assign reply_dr = reply_dr_q;
    assign reply_mb = reply_mb_q;
    assign bcast_active = (state_q == ST_BCAST);

    // Checks
    a_start_no_aicb: assert property (@(posedge aclk) disable iff (!aresetn)
        bcast_start |-> (aicb == '0)) else $error("broadcast began during air-initiated traffic");
    a_aicb_reply: assert property (@(posedge aclk) disable iff (!aresetn)
        aicb[reply_ii] |=> (reply_dr == DR_AICB) && (reply_mb == '0))
        else $error("broadcast shown during air-initiated traffic");
    a_no_preempt: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_BCAST) && (owed != '0) |=> $stable(cur_mb_q)) else $error("current message replaced");
    a_expiry_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_BCAST) && (owed == '0) |=> (num_q != $past(num_q)) && (cur_mb_q == '0)
        && (state_q == ST_IDLE)) else $error("expiry did not toggle and clear");
    a_aicb_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        ai_start_hit[0] && g_ii[0].owed_q |=> (g_ii[0].tmr_q == HOLD_TICKS) && g_ii[0].aicb_q)
        else $error("timer not cleared on air-initiated start");
    a_resume_fresh: assert property (@(posedge aclk) disable iff (!aresetn)
        ai_end_hit[3] && g_ii[3].owed_q && !bcast_start |=> g_ii[3].tmr_q == HOLD_TICKS)
        else $error("no fresh hold after air-initiated end");
    a_load_timer: assert property (@(posedge aclk) disable iff (!aresetn)
        bcast_start |=> (owed == '1) && (g_ii[7].tmr_q == HOLD_TICKS) && (state_q == ST_BCAST))
        else $error("timer not started with broadcast");
    a_latest_value: assert property (@(posedge aclk) disable iff (!aresetn)
        fid_wr && (new_mb != last_fid_q) |=> pfid_q && (pfid_mb_q == $past(new_mb)))
        else $error("waiting value not replaced");
    a_dup_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        dlc_wr && (new_mb == last_dlc_q) && !pdlc_q && !bcast_start |=> !pdlc_q)
        else $error("unchanged value queued");
    a_no_early_next: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_BCAST) && (owed != '0) |=> (state_q == ST_BCAST))
        else $error("next broadcast before all timers expired");
    a_dr_alternate: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_BCAST) && owed[reply_ii] && !aicb[reply_ii]
        |=> reply_dr == ($past(num_q) ? DR_BCAST2 : DR_BCAST1))
        else $error("wrong broadcast request code");
    a_tick_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        g_ii[0].owed_q && !g_ii[0].aicb_q && tick && (g_ii[0].tmr_q > 5'h01) && !bcast_start && !ai_start_hit[0]
        && !ai_end_hit[0] |=> g_ii[0].tmr_q == $past(g_ii[0].tmr_q) - 5'h01)
        else $error("timer did not count tick");
endmodule

// *** sim/cbs_interrogator.sv ***
`timescale 1ns/1ns
module cbs_interrogator (
    // Clock
    input wire logic aclk,
    // Identifier chosen by the bench
    input wire logic [3:0] want_ii,
    // Reply side of the sequencer
    output logic [3:0] reply_ii,
    input wire logic [4:0] reply_dr,
    input wire logic [cbs_pkg::MB_W-1:0] reply_mb,
    // Last message read out
    output logic [cbs_pkg::MB_W-1:0] got_mb
);
    import cbs_pkg::*;
    initial reply_ii = 4'h0;
    initial got_mb = '0;
    // Read out only what is announced
    always @(posedge aclk) begin
        reply_ii <= want_ii;
        if (reply_dr == DR_BCAST1 || reply_dr == DR_BCAST2) begin
            got_mb <= reply_mb;
        end
    end
endmodule

// *** sim/commb_broadcast_sequencer_bench.sv ***
`timescale 1ns/1ns
module commb_broadcast_sequencer_bench;
    import cbs_pkg::*;
    localparam int unsigned TC = 10; // Cycles per tick
    // Clock, reset and bus
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0000_0000, r_data;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0] b_resp, r_resp;
    // Reply side
    logic [3:0] want_ii = 4'h0, reply_ii;
    logic [4:0] reply_dr;
    logic [MB_W-1:0] reply_mb, got_mb;
    logic bcast_active;
    // Reference model: waiting messages, sources, last values, number
    logic [MB_W-1:0] mq[$];
    int sq[$];
    logic [MB_W-1:0] last_v[2] = '{default: '0};
    logic num = 1'b0;
    logic [MB_W-1:0] v[8];
    int n_errors = 0, checks_done = 0, cyc = 0, t0 = 0;

    always #5 aclk = ~aclk;

    cbs_seq #(.TICK_CYCLES(TC)) i_cbs_seq (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
        .s_axi_wdata(w_data), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
        .s_axi_araddr(ar_addr), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
        .reply_ii(reply_ii), .reply_dr(reply_dr), .reply_mb(reply_mb), .bcast_active(bcast_active));

    cbs_interrogator i_cbs_interrogator (.aclk(aclk), .want_ii(want_ii), .reply_ii(reply_ii),
        .reply_dr(reply_dr), .reply_mb(reply_mb), .got_mb(got_mb));

    // Verdict and end of run
    task stop_test;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog against hangs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test;
        end
    end

    // Compare one value
    task chk(input logic [63:0] g, input logic [63:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Register write, address and data offered together
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        aw_addr <= a;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do @(negedge aclk); while ((aw_ready && w_ready) !== 1'b1);
        @(posedge aclk);
        aw_valid <= 1'b0;
        w_valid <= 1'b0;
        do @(negedge aclk); while (b_valid !== 1'b1);
        chk(64'(b_resp), 64'(RESP_OKAY));
        @(posedge aclk);
        b_ready <= 1'b0;
    endtask

    // Register read
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do @(negedge aclk); while (ar_ready !== 1'b1);
        @(posedge aclk);
        ar_valid <= 1'b0;
        do @(negedge aclk); while (r_valid !== 1'b1);
        d = r_data;
        r = r_resp;
        @(posedge aclk);
        r_ready <= 1'b0;
    endtask

    // Source enters a message; model queues or replaces it
    task enter(input int s, input logic [MB_W-1:0] m);
        int k;
        k = -1;
        wr(s ? OFS_DLC_LO : OFS_FID_LO, m[31:0]);
        wr(s ? OFS_DLC_HI : OFS_FID_HI, {8'h00, m[MB_W-1:32]});
        if (m !== last_v[s]) begin
            last_v[s] = m;
            foreach (sq[i]) if (sq[i] == s) k = i;
            if (k >= 0) begin
                mq[k] = m;
            end else begin
                mq.push_back(m);
                sq.push_back(s);
            end
        end
    endtask

    // Broadcast begins: check code, readout and current buffer
    task wait_on;
        logic [MB_W-1:0] e;
        logic [31:0] lo, hi;
        logic [1:0] r;
        do @(negedge aclk); while (bcast_active !== 1'b1);
        t0 = cyc;
        repeat (4) @(negedge aclk);
        e = mq.pop_front();
        void'(sq.pop_front());
        chk(64'(reply_dr), 64'(num ? DR_BCAST2 : DR_BCAST1));
        chk(64'(got_mb), 64'(e));
        rd(OFS_CUR_LO, lo, r);
        rd(OFS_CUR_HI, hi, r);
        chk(64'({hi[23:0], lo}), 64'(e));
        num = ~num;
    endtask

    // Broadcast ends: hold time measured from t0
    task wait_off;
        do @(negedge aclk); while (bcast_active === 1'b1);
        chk(64'(cyc - t0 >= 17 * TC - 4 && cyc - t0 <= 18 * TC + 4), 64'(1));
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(30));
        foreach (v[i]) v[i] = MB_W'({$urandom(), $urandom()}) | 56'h1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_STATUS, d, r);
        chk(64'(d), 64'(0));
        rd(8'h40, d, r);
        chk(64'(r), 64'(RESP_SLVERR));
        enter(0, v[0]);
        wait_on;
        enter(1, v[1]);
        enter(0, v[2]);
        enter(0, v[3]);
        chk(64'(got_mb), 64'(v[0]));
        wait_off;
        wait_on;
        wait_off;
        wait_on;
        wait_off;
        repeat (4) @(negedge aclk);
        chk(64'({reply_dr, reply_mb}), 64'(0));
        enter(0, v[3]);
        enter(1, v[1]);
        repeat (20) @(negedge aclk);
        chk(64'(bcast_active), 64'(0));
        enter(0, v[4]);
        wait_on;
        wr(OFS_AICB, 32'h0000_0001);
        repeat (4) @(negedge aclk);
        chk(64'({reply_dr, reply_mb}), 64'({DR_AICB, 56'h0}));
        repeat (20 * TC) @(negedge aclk);
        wr(OFS_AICB, 32'h0000_0002);
        t0 = cyc;
        wait_off;
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_AICB, 32'h0000_0001);
        enter(1, v[5]);
        repeat (30) @(negedge aclk);
        chk(64'(bcast_active), 64'(0));
        wr(OFS_AICB, 32'h0000_0002);
        wait_on;
        wr(OFS_AICB, 32'h0000_0031);
        @(posedge aclk);
        want_ii <= 4'h3;
        repeat (4) @(negedge aclk);
        chk(64'(reply_dr), 64'(DR_AICB));
        @(posedge aclk);
        want_ii <= 4'h5;
        repeat (4) @(negedge aclk);
        chk(64'(reply_dr), 64'(DR_BCAST1));
        enter(0, v[6]);
        repeat (20 * TC) @(negedge aclk);
        chk(64'(bcast_active), 64'(1));
        wr(OFS_AICB, 32'h0000_0032);
        t0 = cyc;
        wait_off;
        wait_on;
        stop_test;
    end
endmodule
